//--- logic/fdc_channel_fifo_regs.v
// Overview of operation
// RL1: ID bits 21:16 give extra block count
// RL2: ID revision 15:12, type 31:24, rest zero
// RL3: Two 2-bit interrupt condition fields, reset 00
// RL4: Transmit depth read-only at 27:24 and 15:8
// RL5: Receive depth read-only at 7:0
// RL6: Transmit occupancy at 31:24 and 15:12
// RL7: Receive occupancy at status 23:16
// RL8: Status 7:4 shows receive head channel
// RL9: Status bit 3 marks receive FIFO empty
// RL10: Status bit 2 marks receive FIFO full
// RL11: Status bit 1 marks transmit FIFO empty
// RL12: Status bit 0 marks transmit FIFO full
// RL13: Receive read returns head and pops it
// RL14: Software never reads empty receive FIFO
// RL15: Transmit write appends one 32-bit entry
// RL16: Channel tag from address, 8-byte steps
// RL17: Software never writes a full transmit FIFO
// RL18: Interrupt follows selected FIFO condition
// RL19: Probe side drains and fills tagged entries
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.vh"

module fdc_channel_fifo_regs #(
    parameter TX_AW       = 6,
    parameter RX_AW       = 6,
    parameter [7:0] TYPE_CODE = 8'h5a,  // Arbitrary identity value
    parameter [3:0] REV_CODE  = 4'h3    // Arbitrary identity value
) (
    // Clock and synchronous reset
    input  wire        ref_clk,
    input  wire        sys_rst,

    // Register bus: write address, data and response
    input  wire [17:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,

    // Register bus: read address and data
    input  wire [17:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,

    // Probe side: oldest transmit entry, held until taken
    output reg  [31:0] sendWord,
    output reg  [3:0]  sendChannel,
    output reg         sendValid,
    input  wire        sendReady,

    // Probe side: entries offered to the receive FIFO
    input  wire [31:0] recvWord,
    input  wire [3:0]  recvChannel,
    input  wire        recvValid,
    output reg         recvReady,

    // Level interrupt, registered
    output reg         irqOut
);
    localparam TXD = 1 << TX_AW;
    localparam RXD = 1 << RX_AW;
    // Depths as reported, sized to their register fields
    localparam [11:0] TX_DEPTH = 12'h001 << TX_AW;
    localparam [7:0]  RX_DEPTH = 8'h01 << RX_AW;

    // Storage: word plus 4-bit channel tag per entry
    reg [35:0]      txMem [0:TXD-1];
    reg [35:0]      rxMem [0:RXD-1];

    // Pointers carry one extra bit to tell full from empty
    reg [TX_AW:0]   txWp_r;
    reg [TX_AW:0]   txRp_r;
    reg [RX_AW:0]   rxWp_r;
    reg [RX_AW:0]   rxRp_r;

    // Software-visible condition, interrupt status and mask
    reg [1:0]       txCond_r;
    reg [1:0]       rxCond_r;
    reg [1:0]       irqStat_r;
    reg [1:0]       irqMask_r;

    // Write halves wait here until both have arrived
    reg [17:0]      awAddr_r;
    reg             awHave_r;
    reg [31:0]      wData_r;
    reg             wHave_r;

    // Combinational occupancy and read selection
    reg [11:0]      txCount;
    reg [7:0]       rxCount;
    reg [31:0]      rdMux;
    reg [1:0]       rdResp;

    // Flags and head of the receive FIFO
    wire            txEmpty;
    wire            txFull;
    wire            rxEmpty;
    wire            rxFull;
    wire [35:0]     rxHead;

    // Transfer strobes and decode
    wire            wrFire;
    wire            rdFire;
    wire            txPush;
    wire            rxPop;
    wire            sendTake;
    wire            recvTake;
    wire            txInRange;
    wire [17:0]     txRel;
    wire [1:0]      irqEvent;

    // Occupancy from pointer difference; the extra pointer bit tells full from empty
    always @* begin
        txCount = 12'h000;
        rxCount = 8'h00;
        // The entry parked in the send register has not left yet, so it still counts
        txCount[TX_AW:0] = txWp_r - txRp_r + {{TX_AW{1'b0}}, sendValid};  // [RL6]
        rxCount[RX_AW:0] = rxWp_r - rxRp_r;  // [RL7]
    end

    assign txEmpty = (txCount == 12'h000);
    assign txFull  = (txCount == TX_DEPTH);
    assign rxEmpty = (rxWp_r == rxRp_r);
    assign rxFull  = (rxCount == RX_DEPTH);
    assign rxHead  = rxMem[rxRp_r[RX_AW-1:0]];

    // Write channel: address and data may arrive in either order
    assign wrFire    = awHave_r && wHave_r && !s_axi_bvalid;
    assign txRel     = awAddr_r - `FDC_OFF_TXBASE;
    assign txInRange = (awAddr_r >= `FDC_OFF_TXBASE) && (awAddr_r <= `FDC_OFF_TXLAST) && (awAddr_r[2:0] == 3'h0);
    // A push to a full FIFO is dropped rather than corrupting the oldest entry
    assign txPush    = wrFire && txInRange && !txFull;  // [RL15] [RL17]
    assign rdFire    = s_axi_arvalid && s_axi_arready;
    // Popping an empty FIFO would wrap the pointers, so it is ignored
    assign rxPop     = rdFire && (s_axi_araddr == `FDC_OFF_RXPOP) && !rxEmpty;  // [RL13] [RL14]
    assign sendTake  = sendValid && sendReady;
    assign recvTake  = recvValid && recvReady;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FDC_RESP_OKAY;
            awHave_r      <= 1'b0;
            wHave_r       <= 1'b0;
            awAddr_r      <= 18'h00000;
            wData_r       <= 32'h00000000;
            txCond_r      <= `FDC_IRQ_COND_RST;
            rxCond_r      <= `FDC_IRQ_COND_RST;
            irqMask_r     <= 2'h0;
        end else begin
            s_axi_awready <= !awHave_r && !s_axi_awready;
            s_axi_wready  <= !wHave_r && !s_axi_wready;

            // Address half
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end

            // Data half
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end

            // Both halves held: act on the register, then answer
            if (wrFire) begin
                awHave_r     <= 1'b0;
                wHave_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `FDC_RESP_OKAY;
                if (awAddr_r == `FDC_OFF_CONFIG) begin
                    txCond_r <= wData_r[`FDC_CFG_TXIRQ_HI:`FDC_CFG_TXIRQ_LO];  // [RL3]
                    rxCond_r <= wData_r[`FDC_CFG_RXIRQ_HI:`FDC_CFG_RXIRQ_LO];  // [RL3]
                end else if (awAddr_r == `FDC_OFF_IRQMASK) begin
                    irqMask_r <= wData_r[1:0];
                end else if (!txInRange && awAddr_r != `FDC_OFF_IDENT && awAddr_r != `FDC_OFF_STATUS
                             && awAddr_r != `FDC_OFF_RXPOP && awAddr_r != `FDC_OFF_IRQSTAT) begin
                    s_axi_bresp <= `FDC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Transmit FIFO: software fills, probe side drains
    always @(posedge ref_clk) begin
        if (txPush) begin
            txMem[txWp_r[TX_AW-1:0]] <= {txRel[6:3], wData_r};  // [RL16]
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            txWp_r    <= {(TX_AW+1){1'b0}};
            txRp_r    <= {(TX_AW+1){1'b0}};
            sendValid <= 1'b0;
            sendWord  <= 32'h00000000;
            sendChannel <= 4'h0;
        end else begin
            // Software push
            if (txPush) begin
                txWp_r <= txWp_r + 1'b1;  // [RL15]
            end

            // Output stage is a register, so refill only when it is free or being taken
            if (!sendValid || sendTake) begin
                if (txWp_r != txRp_r) begin
                    sendValid   <= 1'b1;  // [RL19]
                    sendWord    <= txMem[txRp_r[TX_AW-1:0]][31:0];
                    sendChannel <= txMem[txRp_r[TX_AW-1:0]][35:32];
                    txRp_r      <= txRp_r + 1'b1;
                end else begin
                    sendValid <= 1'b0;
                end
            end
        end
    end

    // Receive FIFO: probe side fills, software pops
    always @(posedge ref_clk) begin
        if (recvTake) begin
            rxMem[rxWp_r[RX_AW-1:0]] <= {recvChannel, recvWord};  // [RL19]
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rxWp_r    <= {(RX_AW+1){1'b0}};
            rxRp_r    <= {(RX_AW+1){1'b0}};
            recvReady <= 1'b0;
        end else begin
            // Probe push
            if (recvTake) begin
                rxWp_r <= rxWp_r + 1'b1;
            end

            // Software pop
            if (rxPop) begin
                rxRp_r <= rxRp_r + 1'b1;  // [RL13]
            end

            // Ready looks one entry ahead so a take never lands on a full FIFO
            recvReady <= (rxCount + (recvTake ? 8'h01 : 8'h00) - (rxPop ? 8'h01 : 8'h00)) < RX_DEPTH;
        end
    end

    // Read data selection
    always @* begin
        rdMux  = 32'h00000000;
        rdResp = `FDC_RESP_OKAY;
        case (s_axi_araddr)
            `FDC_OFF_IDENT: begin
                rdMux[`FDC_ID_TYPE_HI:`FDC_ID_TYPE_LO] = TYPE_CODE;         // [RL2]
                rdMux[`FDC_ID_SIZE_HI:`FDC_ID_SIZE_LO] = `FDC_EXTRA_BLOCKS; // [RL1]
                rdMux[`FDC_ID_REV_HI:`FDC_ID_REV_LO]   = REV_CODE;          // [RL2]
            end

            `FDC_OFF_CONFIG: begin
                rdMux[`FDC_CFG_TXDH_HI:`FDC_CFG_TXDH_LO]   = TX_DEPTH[11:8];  // [RL4]
                rdMux[`FDC_CFG_TXIRQ_HI:`FDC_CFG_TXIRQ_LO] = txCond_r;
                rdMux[`FDC_CFG_RXIRQ_HI:`FDC_CFG_RXIRQ_LO] = rxCond_r;
                rdMux[`FDC_CFG_TXDL_HI:`FDC_CFG_TXDL_LO]   = TX_DEPTH[7:0];   // [RL4]
                rdMux[`FDC_CFG_RXD_HI:`FDC_CFG_RXD_LO]     = RX_DEPTH;        // [RL5]
            end

            `FDC_OFF_STATUS: begin
                rdMux[`FDC_ST_TXCL_HI:`FDC_ST_TXCL_LO] = txCount[7:0];   // [RL6]
                rdMux[`FDC_ST_RXC_HI:`FDC_ST_RXC_LO]   = rxCount;        // [RL7]
                rdMux[`FDC_ST_TXCH_HI:`FDC_ST_TXCH_LO] = txCount[11:8];  // [RL6]
                // Head channel means nothing while empty; zero beats stale or unknown data
                rdMux[`FDC_ST_CHAN_HI:`FDC_ST_CHAN_LO] = rxEmpty ? 4'h0 : rxHead[35:32];  // [RL8]
                rdMux[`FDC_ST_RXE] = rxEmpty;  // [RL9]
                rdMux[`FDC_ST_RXF] = rxFull;   // [RL10]
                rdMux[`FDC_ST_TXE] = txEmpty;  // [RL11]
                rdMux[`FDC_ST_TXF] = txFull;   // [RL12]
            end

            `FDC_OFF_RXPOP: begin
                rdMux = rxHead[31:0];  // [RL13]
            end

            `FDC_OFF_IRQSTAT: begin
                rdMux[1:0] = irqStat_r;
            end

            `FDC_OFF_IRQMASK: begin
                rdMux[1:0] = irqMask_r;
            end

            default: begin
                // Transmit slots read as zero; anything else is unmapped
                if (!((s_axi_araddr >= `FDC_OFF_TXBASE) && (s_axi_araddr <= `FDC_OFF_TXLAST))) begin
                    rdResp = `FDC_RESP_SLVERR;
                end
            end
        endcase
    end

    // Read channel: one read in flight, answer one cycle after the address is taken
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `FDC_RESP_OKAY;
        end else begin
            // One address per answer; the slot right after a take stays closed
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rdFire;

            if (rdFire) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdMux;
                s_axi_rresp   <= rdResp;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Condition per FIFO, chosen by its condition field
    function cond_true;
        input [1:0] sel;
        input       full;
        input       empty;
        input [11:0] cnt;
        input [11:0] depth;
        begin
            case (sel)
                `FDC_COND_FULL:     cond_true = full;
                `FDC_COND_NOTEMPTY: cond_true = !empty;
                `FDC_COND_ALMOST:   cond_true = (cnt + 12'h001) >= depth;
                default:            cond_true = 1'b0;
            endcase
        end
    endfunction

    assign irqEvent[`FDC_IRQ_TX] = cond_true(txCond_r, txFull, txEmpty, txCount, TX_DEPTH);  // [RL18]
    assign irqEvent[`FDC_IRQ_RX] = cond_true(rxCond_r, rxFull, rxEmpty, {4'h0, rxCount}, {4'h0, RX_DEPTH});  // [RL18]

    // Sticky status: a live condition wins over the read that clears it
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            irqStat_r <= 2'h0;
            irqOut    <= 1'b0;
        end else begin
            if (rdFire && s_axi_araddr == `FDC_OFF_IRQSTAT) begin
                irqStat_r <= irqEvent;
            end else begin
                irqStat_r <= irqStat_r | irqEvent;  // [RL18]
            end

            // Live condition included so the pin does not lag the status bit
            irqOut <= |((irqStat_r | irqEvent) & irqMask_r);
        end
    end
endmodule
`default_nettype wire

//--- logic/fdc_regs.vh
`ifndef FDC_REGS_VH
`define FDC_REGS_VH

// Register byte offsets inside the 0x3f000-based block
`define FDC_ADDR_W          18
`define FDC_OFF_IDENT       18'h3f000
`define FDC_OFF_CONFIG      18'h3f008
`define FDC_OFF_STATUS      18'h3f010
`define FDC_OFF_RXPOP       18'h3f018
`define FDC_OFF_TXBASE      18'h3f020
`define FDC_OFF_TXLAST      18'h3f098
`define FDC_OFF_IRQSTAT     18'h3f0a0
`define FDC_OFF_IRQMASK     18'h3f0a8
`define FDC_OFF_PROBE       18'h3f0b0

// Identification fields
`define FDC_ID_TYPE_HI      31
`define FDC_ID_TYPE_LO      24
`define FDC_ID_SIZE_HI      21
`define FDC_ID_SIZE_LO      16
`define FDC_ID_REV_HI       15
`define FDC_ID_REV_LO       12
`define FDC_EXTRA_BLOCKS    6'h02

// Configuration fields
`define FDC_CFG_TXDH_HI     27
`define FDC_CFG_TXDH_LO     24
`define FDC_CFG_TXIRQ_HI    19
`define FDC_CFG_TXIRQ_LO    18
`define FDC_CFG_RXIRQ_HI    17
`define FDC_CFG_RXIRQ_LO    16
`define FDC_CFG_TXDL_HI     15
`define FDC_CFG_TXDL_LO     8
`define FDC_CFG_RXD_HI      7
`define FDC_CFG_RXD_LO      0
`define FDC_IRQ_COND_RST    2'h0

// Interrupt condition codes
`define FDC_COND_NONE       2'h0
`define FDC_COND_FULL       2'h1
`define FDC_COND_NOTEMPTY   2'h2
`define FDC_COND_ALMOST     2'h3

// Status fields
`define FDC_ST_TXCL_HI      31
`define FDC_ST_TXCL_LO      24
`define FDC_ST_RXC_HI       23
`define FDC_ST_RXC_LO       16
`define FDC_ST_TXCH_HI      15
`define FDC_ST_TXCH_LO      12
`define FDC_ST_CHAN_HI      7
`define FDC_ST_CHAN_LO      4
`define FDC_ST_RXE          3
`define FDC_ST_RXF          2
`define FDC_ST_TXE          1
`define FDC_ST_TXF          0

// Sticky interrupt status bits
`define FDC_IRQ_TX          0
`define FDC_IRQ_RX          1

// AXI responses
`define FDC_RESP_OKAY       2'h0
`define FDC_RESP_SLVERR     2'h2

`endif

//--- verif/fdc_channel_fifo_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.vh"
module fdc_channel_fifo_regs_tb_top;
    localparam logic [7:0] TC = 8'hc3;  // Arbitrary identity value
    localparam logic [3:0] RC = 4'h6;   // Arbitrary identity value
    localparam int         D  = 8;      // Depth for address width 3, keeps fills short
    logic        ref_clk, sys_rst, holdOff;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, sendWord, recvWord, rd;
    logic [3:0]  s_axi_wstrb, sendChannel, recvChannel;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        sendValid, sendReady, recvValid, recvReady, irqOut;
    logic [35:0] expQ[$], e;
    integer      errors, compares, seed, i, b, n;

    fdc_channel_fifo_regs #(.TX_AW(3), .RX_AW(3), .TYPE_CODE(TC), .REV_CODE(RC)) dut (
        .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sendWord, .sendChannel, .sendValid, .sendReady, .recvWord, .recvChannel, .recvValid,
        .recvReady, .irqOut);
    fdc_probe_model probe (.ref_clk, .holdOff, .sendWord, .sendChannel, .sendValid, .sendReady,
        .recvWord, .recvChannel, .recvValid, .recvReady);

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        errors = errors + 1;
        $display("[ERR] %0t no answer", $time);
        print_verdict();
    endtask
    // Ready raised only once valid is seen, so the slave must hold its answer
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 99) hang();
    endtask
    task automatic rdr(input logic [17:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 99) hang();
    endtask
    // Pops only while the reference says entries remain
    task automatic popOne();
        e = expQ.pop_front();
        rdr(`FDC_OFF_STATUS);
        check(rd[7:4], e[35:32]);
        rdr(`FDC_OFF_RXPOP);
        check(rd, e[31:0]);
    endtask
    initial begin
        seed = 32'hfd85;
        errors = 0;
        compares = 0;
        holdOff = 1'b1;
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdr(`FDC_OFF_IDENT);
        check(rd, {TC, 8'h02, RC, 12'h0});
        rdr(`FDC_OFF_STATUS);
        check(rd, 32'h0000000a);
        wr(`FDC_OFF_CONFIG, '1);
        rdr(`FDC_OFF_CONFIG);
        check(rd, 32'h000f0808);
        // Fill the receive side with exactly D entries, up to full
        for (i = 0; i < D; i++) begin
            e = {4'(i * 5), 32'($random(seed))};
            probe.feedQ.push_back(e);
            expQ.push_back(e);
        end
        for (n = 0; n < 99 && probe.feedQ.size() > 0; n++) @(posedge ref_clk);
        if (n == 99) hang();
        repeat (2) @(posedge ref_clk);
        rdr(`FDC_OFF_STATUS);
        check(rd, {8'h00, 8'(D), 8'h00, expQ[0][35:32], 4'h6});
        popOne();
        // Masked first, then every condition code with one free entry
        wr(`FDC_OFF_IRQMASK, 32'h0);
        wr(`FDC_OFF_CONFIG, 32'h00020000);
        rdr(`FDC_OFF_IRQSTAT);
        repeat (3) @(posedge ref_clk);
        check(irqOut, 1'b0);
        wr(`FDC_OFF_IRQMASK, 32'h2);
        for (i = 0; i < 4; i++) begin
            wr(`FDC_OFF_CONFIG, 32'(i) << 16);
            rdr(`FDC_OFF_IRQSTAT);
            repeat (3) @(posedge ref_clk);
            check(irqOut, i >= 2);
        end
        while (expQ.size() > 0) popOne();
        rdr(`FDC_OFF_STATUS);
        check(rd, 32'h0000000a);
        // Sixteen channels in two batches, probe stalled while each is written
        for (b = 0; b < 2; b++) begin
            holdOff <= 1'b1;
            for (i = 0; i < D; i++) begin
                e = {4'(b * D + i), 32'($random(seed))};
                expQ.push_back(e);
                wr(`FDC_OFF_TXBASE + 18'(8 * e[35:32]), e[31:0]);
            end
            rdr(`FDC_OFF_STATUS);
            check(rd, {8'(D), 16'h0000, 8'h09});
            wr(`FDC_OFF_IRQMASK, 32'h1);
            wr(`FDC_OFF_CONFIG, 32'h00040000);
            repeat (3) @(posedge ref_clk);
            check(irqOut, 1'b1);
            holdOff <= 1'b0;
            for (n = 0; n < 400 && probe.gotQ.size() < D; n++) @(posedge ref_clk);
            if (n == 400) hang();
            while (expQ.size() > 0) check(probe.gotQ.pop_front(), expQ.pop_front());
        end
        rdr(`FDC_OFF_STATUS);
        check(rd, 32'h0000000a);
        rdr(`FDC_OFF_PROBE);
        check(rs, `FDC_RESP_SLVERR);
        wr(`FDC_OFF_PROBE, 32'h0);
        check(rs, `FDC_RESP_SLVERR);
        // Second reset in mid-run clears the written condition fields
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdr(`FDC_OFF_CONFIG);
        check(rd, 32'h00000808);
        check(irqOut, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire

//--- verif/fdc_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
// Debug probe stand-in: drains the send side, feeds the receive side
module fdc_probe_model (
    input  wire logic        ref_clk,
    input  wire logic        holdOff,
    input  wire logic [31:0] sendWord,
    input  wire logic [3:0]  sendChannel,
    input  wire logic        sendValid,
    output var  logic        sendReady,
    output var  logic [31:0] recvWord,
    output var  logic [3:0]  recvChannel,
    output var  logic        recvValid,
    input  wire logic        recvReady
);
    logic [35:0] feedQ[$];  // Entries the bench wants pushed
    logic [35:0] gotQ[$];   // Entries drained, channel on top
    logic        slow;
    initial begin
        slow = 1'b0;
        sendReady = 1'b0;
        recvValid = 1'b0;
        {recvChannel, recvWord} = 36'h0;
    end
    // Ready only every other cycle, never while held off, so the send side sees stalls
    always @(posedge ref_clk) begin
        if (sendValid && sendReady)
            gotQ.push_back({sendChannel, sendWord});
        slow <= ~slow;
        sendReady <= !holdOff && slow;
    end
    // Head entry held until taken; idle lines flip each cycle so stale data never looks valid
    always @(posedge ref_clk) begin
        if (recvValid && recvReady)
            void'(feedQ.pop_front());
        recvValid <= feedQ.size() > 0;
        if (feedQ.size() > 0)
            {recvChannel, recvWord} <= feedQ[0];
        else
            {recvChannel, recvWord} <= ~{recvChannel, recvWord};
    end
endmodule
`default_nettype wire

//--- verif/fdc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.vh"
module fdc_regs_sva (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] sendWord,
    input wire logic        sendValid,
    input wire logic        sendReady
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Reset itself is watched, so this one is never disabled
    chk_reset_idle: assert property (disable iff (1'b0)
        sys_rst |=> !s_axi_bvalid && !s_axi_rvalid && !sendValid) else $error("busy after reset");
    // Both halves taken together: response two edges later
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write unanswered");
    chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read unanswered");
    chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
    chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `FDC_OFF_PROBE
        |=> s_axi_rresp == `FDC_RESP_SLVERR) else $error("unmapped read accepted");
    chk_ident_fields: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `FDC_OFF_IDENT
        |=> s_axi_rdata[23:16] == {2'h0, `FDC_EXTRA_BLOCKS} && s_axi_rdata[11:0] == 12'h0)
        else $error("identification wrong");
    chk_send_holds: assert property (sendValid && !sendReady
        |=> sendValid && $stable(sendWord)) else $error("send entry changed");
endmodule
bind fdc_channel_fifo_regs fdc_regs_sva u_sva (.ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sendWord, .sendValid, .sendReady);
`default_nettype wire
